//--- rtl/c16_top.sv
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - Sixteen-bit count in two bytes counts up, wrapping from all ones to zero.
// - Wrap from maximum to zero raises an overflow event.
// - Overflow latches flag bit 0 of the flag register until cleared.
// - Interrupt request goes out only when enable bit 0 is set.
// - Control bit 0 runs or stops counting; resets to zero.
// - Control bit 1 picks instruction clock or external pin rising edges.
// - Timer advances per instruction cycle; counter per external rising edge.
// - Control bits 5:4 prescale by 1, 2, 4 or 8.
// - Control bit 2 chooses synchronised or unsynchronised external counting.
// - Synchronise bit is ignored when internal clock is selected.
// - Control bit 3 turns the crystal oscillator on or off.
// - Oscillator on forces shared pins 0 and 1 to inputs.
// - Oscillator keeps running in sleep; rated up to 200 kHz.
// - Capture/compare trigger input clears the count.
// - Control bits 7:6 ignore writes and read zero.
// - Trigger clear never sets the overflow flag.
// - A count write in the trigger cycle wins over the clear.
module c16_top (
    // Clock and reset.
    input  wire logic                          mclk,
    input  wire logic                          rst,
    // Avalon-MM register slave.
    input  wire logic [c16_pkg::ADDR_W-1:0]    avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [c16_pkg::DATA_W-1:0]    avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output logic      [c16_pkg::DATA_W-1:0]    avs_readdata,
    output logic                               avs_waitrequest,
    // Count inputs.
    input  wire logic                          ext_count_clock_pin,
    input  wire logic                          capture_compare_reset,
    input  wire logic                          sleep_active,
    // Shared pin override.
    input  wire logic [1:0]                    port_direction,
    output logic      [1:0]                    shared_pin_oe_n,
    // Status toward the system.
    output logic                               crystal_osc_run,
    output logic                               overflow_irq,
    output logic      [15:0]                   count_value
);
    import c16_pkg::*;

    c16_tick_if ps ();

    logic [7:0]        ctrl_ff;
    logic [15:0]       count_ff;
    logic [15:0]       nxt_count;
    logic              flag_ff;
    logic              ien_ff;
    logic              wait_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic              irq_ff;
    logic [1:0]        pin_oe_n_ff;
    logic              osc_ff;
    logic [1:0]        div_ff;
    logic              raw_ff;
    logic              raw_prev_ff;
    logic              sync_rise;
    logic              raw_rise;
    logic              instr_tick;
    logic              base_tick;
    logic              accept;
    logic              wr_acc;
    logic              wr_lo;
    logic              wr_hi;
    logic              wr_cnt;
    logic              wr_ctrl;
    logic              wr_flags;
    logic              wr_ien;
    logic              evt_clr;
    logic              inc;
    logic              ovf;
    c16_src_e          src_mode;

    // Byte address of a register from its index.
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        return a == {idx, 2'b00};
    endfunction : hit

    // Bus decode. A request is taken on the edge where waitrequest is low.
    assign accept   = (avs_read | avs_write) & ~wait_ff;
    assign wr_acc   = avs_write & ~wait_ff & avs_byteenable[0];
    assign wr_lo    = wr_acc & hit(avs_address, IDX_CNT_LO);
    assign wr_hi    = wr_acc & hit(avs_address, IDX_CNT_HI);
    assign wr_ctrl  = wr_acc & hit(avs_address, IDX_CTRL);
    assign wr_flags = wr_acc & hit(avs_address, IDX_FLAGS);
    assign wr_ien   = wr_acc & hit(avs_address, IDX_ENABLES);
    assign wr_cnt   = wr_lo | wr_hi;

    // One wait cycle per access so read data can come from a flop.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wait_ff <= 1'b1;
        end else if (avs_read | avs_write) begin
            wait_ff <= ~wait_ff;
        end else begin
            wait_ff <= 1'b1;
        end
    end

    // Read mux; unmapped addresses read zero.
    always_comb begin
        nxt_rdata = '0;
        if (hit(avs_address, IDX_CTRL)) begin
            nxt_rdata[7:0] = ctrl_ff & CTRL_WR_MASK;
        end else if (hit(avs_address, IDX_CNT_LO)) begin
            nxt_rdata[7:0] = count_ff[7:0];
        end else if (hit(avs_address, IDX_CNT_HI)) begin
            nxt_rdata[7:0] = count_ff[15:8];
        end else if (hit(avs_address, IDX_FLAGS)) begin
            nxt_rdata[FLAG_OVF_BIT] = flag_ff;
        end else if (hit(avs_address, IDX_ENABLES)) begin
            nxt_rdata[FLAG_OVF_BIT] = ien_ff;
        end
    end

    // Read data is captured in the wait cycle and stands while waitrequest is low.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_ff <= '0;
        end else if (avs_read && wait_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Control register; the top two bits are never stored.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= avs_writedata[7:0] & CTRL_WR_MASK;
        end
    end

    // Interrupt enable register.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ien_ff <= IEN_RESET;
        end else if (wr_ien) begin
            ien_ff <= avs_writedata[FLAG_OVF_BIT];
        end
    end

    // Instruction clock divider. It keeps counting in sleep; only its tick is masked by sleep_active.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_ff <= 2'h0;
        end else if (div_ff == INSTR_LAST) begin
            div_ff <= 2'h0;
        end else begin
            div_ff <= div_ff + 2'h1;
        end
    end

    assign instr_tick = (div_ff == INSTR_LAST) & ~sleep_active;

    // Synchronised path for the external clock pin.
    c16_sync u_sync (
        .mclk (mclk),
        .rst  (rst),
        .d    (ext_count_clock_pin),
        .rise (sync_rise)
    );

    // Unsynchronised path: one sample only, so it answers a cycle sooner.
    // It trades metastability margin for latency and keeps counting in sleep.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            raw_ff      <= 1'b0;
            raw_prev_ff <= 1'b0;
        end else begin
            raw_ff      <= ext_count_clock_pin;
            raw_prev_ff <= raw_ff;
        end
    end

    assign raw_rise = raw_ff & ~raw_prev_ff;

    // Count source; the sync bit matters only for the external source.
    always_comb begin
        if (!ctrl_ff[CTRL_SRC_BIT]) begin
            src_mode = C16_SRC_INSTR;
        end else if (ctrl_ff[CTRL_ASYNC_BIT]) begin
            src_mode = C16_SRC_ASYNC;
        end else begin
            src_mode = C16_SRC_SYNC;
        end
    end

    // Tick of the selected source before the prescaler.
    always_comb begin
        case (src_mode)
            C16_SRC_INSTR: base_tick = instr_tick;
            C16_SRC_SYNC:  base_tick = sync_rise & ~sleep_active;
            C16_SRC_ASYNC: base_tick = raw_rise;
            default:       base_tick = 1'b0;
        endcase
    end

    // Prescaler hookup; writing the count restarts the ratio.
    assign ps.tick = base_tick & ctrl_ff[CTRL_RUN_BIT];
    assign ps.clr  = wr_cnt;
    assign ps.sel  = ctrl_ff[CTRL_PS_MSB:CTRL_PS_LSB];

    c16_prescale u_prescale (
        .mclk (mclk),
        .rst  (rst),
        .p    (ps.scaler)
    );

    // The trigger clears in any mode; unsynchronised use is at software's risk.
    assign evt_clr = capture_compare_reset & ~wr_cnt;
    assign inc     = ps.pulse & ~wr_cnt & ~evt_clr;
    assign ovf     = inc & (count_ff == CNT_MAX);

    // Next count: write first, then trigger clear, then increment.
    always_comb begin
        nxt_count = count_ff;
        if (wr_lo) begin
            nxt_count[7:0] = avs_writedata[7:0];
        end
        if (wr_hi) begin
            nxt_count[15:8] = avs_writedata[7:0];
        end
        if (evt_clr) begin
            nxt_count = CNT_RESET;
        end else if (inc) begin
            nxt_count = count_ff + 16'h0001;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_ff <= CNT_RESET;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // Overflow flag: a set in the clearing cycle wins, the trigger never sets it.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flag_ff <= FLAG_RESET;
        end else if (ovf) begin
            flag_ff <= 1'b1;
        end else if (wr_flags) begin
            flag_ff <= avs_writedata[FLAG_OVF_BIT];
        end
    end

    // Gated request toward the interrupt controller.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= flag_ff & ien_ff;
        end
    end

    // Oscillator enable ignores sleep so the crystal keeps running.
    // Start-up settling is left to software; nothing here waits for it.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            osc_ff <= 1'b0;
        end else begin
            osc_ff <= ctrl_ff[CTRL_OSC_BIT];
        end
    end

    // Shared pins: oscillator on overrides the port direction to input.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_oe_n_ff <= 2'h3;
        end else if (ctrl_ff[CTRL_OSC_BIT]) begin
            pin_oe_n_ff <= 2'h3;
        end else begin
            pin_oe_n_ff <= port_direction;
        end
    end

    // Outputs straight from flops.
    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign shared_pin_oe_n = pin_oe_n_ff;
    assign crystal_osc_run = osc_ff;
    assign overflow_irq    = irq_ff;
    assign count_value     = count_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_ctrl_top_zero: assert property (ctrl_ff[7:6] == 2'h0)
        else $error("Unimplemented control bits became set.");

    a_count_wraps: assert property (ovf |=> count_ff == CNT_RESET)
        else $error("Count did not wrap to zero.");

    a_ovf_flag_set: assert property (ovf |=> flag_ff [*2])
        else $error("Overflow did not latch the flag.");

    a_irq_masked: assert property (!ien_ff [*2] |-> !irq_ff)
        else $error("Interrupt forwarded while disabled.");

    a_irq_follows: assert property ((flag_ff && ien_ff) [*2] |-> irq_ff)
        else $error("Enabled flag did not reach the interrupt.");

    a_stopped_holds: assert property (
        (!ctrl_ff[CTRL_RUN_BIT] && !wr_cnt && !capture_compare_reset)
        |=> $stable(count_ff))
        else $error("Stopped count changed.");

    a_trigger_clears: assert property (evt_clr |=> count_ff == CNT_RESET)
        else $error("Trigger did not clear the count.");

    a_trigger_noflag: assert property (
        (capture_compare_reset && !flag_ff && !wr_cnt) |=> !flag_ff)
        else $error("Trigger clear set the overflow flag.");

    a_write_wins: assert property (
        (wr_lo && capture_compare_reset)
        |=> count_ff[7:0] == $past(avs_writedata[7:0]))
        else $error("Trigger beat a count write.");

    a_pins_input: assert property (ctrl_ff[CTRL_OSC_BIT] |=> shared_pin_oe_n == 2'h3)
        else $error("Shared pin driven with oscillator on.");

    a_internal_src: assert property (
        !ctrl_ff[CTRL_SRC_BIT] |-> src_mode == C16_SRC_INSTR)
        else $error("Sync bit altered the internal source.");

    a_timer_rate: assert property (
        (src_mode == C16_SRC_INSTR && inc) |=> !inc [*3])
        else $error("Timer advanced faster than the instruction clock.");

    a_bus_answer: assert property (
        (avs_read || avs_write) && wait_ff |=> !wait_ff)
        else $error("Waitrequest did not drop after one cycle.");

    c_overflow: cover property (ovf);
    c_trigger: cover property (evt_clr && ctrl_ff[CTRL_RUN_BIT]);
    c_async_count: cover property (src_mode == C16_SRC_ASYNC && inc);
    c_write_vs_trigger: cover property (wr_cnt && capture_compare_reset);
endmodule : c16_top

//--- include/c16_pkg.sv
package c16_pkg;
    // Avalon-MM slave geometry.
    localparam int          ADDR_W        = 10;
    localparam int          DATA_W        = 32;
    // Register indices; the byte address is four times the index.
    localparam logic [7:0]  IDX_FLAGS     = 8'h0c;
    localparam logic [7:0]  IDX_CNT_LO    = 8'h0e;
    localparam logic [7:0]  IDX_CNT_HI    = 8'h0f;
    localparam logic [7:0]  IDX_CTRL      = 8'h10;
    localparam logic [7:0]  IDX_ENABLES   = 8'h8c;
    // Control register fields.
    localparam int          CTRL_RUN_BIT  = 0;
    localparam int          CTRL_SRC_BIT  = 1;
    localparam int          CTRL_ASYNC_BIT = 2;
    localparam int          CTRL_OSC_BIT  = 3;
    localparam int          CTRL_PS_LSB   = 4;
    localparam int          CTRL_PS_MSB   = 5;
    localparam logic [7:0]  CTRL_WR_MASK  = 8'h3f;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    // Flag and enable registers.
    localparam int          FLAG_OVF_BIT  = 0;
    localparam logic        FLAG_RESET    = 1'h0;
    localparam logic        IEN_RESET     = 1'h0;
    // Count register.
    localparam logic [15:0] CNT_RESET     = 16'h0000;
    localparam logic [15:0] CNT_MAX       = 16'hffff;
    // Timing: the instruction clock is one quarter of the main clock.
    localparam int          MCLK_HZ       = 40_000_000;
    localparam int          INSTR_DIV     = 4;
    localparam logic [1:0]  INSTR_LAST    = 2'(INSTR_DIV - 1);
    localparam int          OSC_MAX_HZ    = 200_000;
    localparam int          OSC_MIN_CYC   = MCLK_HZ / OSC_MAX_HZ;
    // Prescaler width for the largest ratio of 1:8.
    localparam int          PS_W          = 3;
    // Count source, one-hot.
    typedef enum logic [2:0] {
        C16_SRC_INSTR = 3'b001,
        C16_SRC_SYNC  = 3'b010,
        C16_SRC_ASYNC = 3'b100
    } c16_src_e;
endpackage : c16_pkg

//--- include/c16_tick_if.sv
`timescale 1ns/1ps
interface c16_tick_if;
    logic       tick;
    logic       clr;
    logic [1:0] sel;
    logic       pulse;
    modport core   (output tick, output clr, output sel, input pulse);
    modport scaler (input tick, input clr, input sel, output pulse);
endinterface : c16_tick_if

//--- rtl/c16_sync.sv
`timescale 1ns/1ps
module c16_sync (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic rst,
    // Raw level in, rising edge out.
    input  wire logic d,
    output logic      rise
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    // Two flops settle the level; the third only serves the edge detector.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            s1_ff <= d;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Edge is taken after the second stage only.
    assign rise = s2_ff & ~s3_ff;
endmodule : c16_sync

//--- rtl/c16_prescale.sv
`timescale 1ns/1ps
module c16_prescale (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Tick link to the core.
    c16_tick_if.scaler p
);
    import c16_pkg::*;

    logic [PS_W-1:0] cnt_ff;
    logic [PS_W-1:0] mask;

    // Ratio select sets how many low bits must be all ones.
    always_comb begin
        case (p.sel)
            2'h0:    mask = 3'h0;
            2'h1:    mask = 3'h1;
            2'h2:    mask = 3'h3;
            default: mask = 3'h7;
        endcase
    end

    // Free count of source ticks, cleared when the count is written.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 3'h0;
        end else if (p.clr) begin
            cnt_ff <= 3'h0;
        end else if (p.tick) begin
            cnt_ff <= cnt_ff + 3'h1;
        end
    end

    assign p.pulse = p.tick & ~p.clr & ((cnt_ff & mask) == mask);

    a_scale_unity: assert property (@(posedge mclk) disable iff (rst)
        (p.sel == 2'h0 && p.tick && !p.clr) |-> p.pulse)
        else $error("Prescaler 1:1 dropped a tick.");
endmodule : c16_prescale

//--- verification/c16_ext_src.sv
`timescale 1ns/1ps
module c16_ext_src (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       rst,
    // Burst request.
    input  wire logic       go,
    input  wire logic [7:0] n_edges,
    input  wire logic [7:0] half,
    // Clock pin toward the counter.
    output logic            pin,
    output logic            busy
);
    logic [7:0] left_ff;
    logic [7:0] cnt_ff;

    // Burst of rising edges, each level held half mclk cycles; the pin rests low between bursts.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin     <= 1'b0;
            busy    <= 1'b0;
            left_ff <= 8'h00;
            cnt_ff  <= 8'h00;
        end else if (go && !busy) begin
            left_ff <= n_edges;
            cnt_ff  <= half;
            busy    <= (n_edges != 8'h00);
        end else if (busy) begin
            if (cnt_ff > 8'h01) begin
                cnt_ff <= cnt_ff - 8'h01;
            end else begin
                cnt_ff <= half;
                pin    <= !pin;
                if (pin) begin
                    left_ff <= left_ff - 8'h01;
                    busy    <= (left_ff != 8'h01);
                end
            end
        end
    end
endmodule : c16_ext_src

//--- verification/counter16_with_ext_clock_bench.sv
`timescale 1ns/1ps
module counter16_with_ext_clock_bench;
    import c16_pkg::*;
    logic                mclk;
    logic                rst;
    logic [ADDR_W-1:0]   avs_address;
    logic                avs_read;
    logic                avs_write;
    logic [DATA_W-1:0]   avs_writedata;
    logic [DATA_W-1:0]   avs_readdata;
    logic                avs_waitrequest;
    logic                ext_pin;
    logic                ccr;
    logic                sleep_active;
    logic [1:0]          port_direction;
    logic [1:0]          shared_pin_oe_n;
    logic                crystal_osc_run;
    logic                overflow_irq;
    logic [15:0]         count_value;
    logic                go;
    logic [7:0]          n_edges;
    logic [7:0]          half;
    logic                busy;
    logic [7:0]          rd;
    logic [15:0]         c0;
    int                  bad_count;
    int                  n_checks;
    int                  k;

    c16_top u_c16_top (
        .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_count_clock_pin(ext_pin), .capture_compare_reset(ccr),
        .sleep_active(sleep_active), .port_direction(port_direction),
        .shared_pin_oe_n(shared_pin_oe_n), .crystal_osc_run(crystal_osc_run),
        .overflow_irq(overflow_irq), .count_value(count_value)
    );

    c16_ext_src u_c16_ext_src (
        .mclk(mclk), .rst(rst), .go(go), .n_edges(n_edges), .half(half),
        .pin(ext_pin), .busy(busy)
    );

    // Free-running 40 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = !mclk;
    end

    // Counts every comparison and reports a mismatch at once.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One Avalon access; the request is held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic trig);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address   <= {idx, 2'b00};
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_writedata <= {24'h000000, wd};
        ccr           <= trig;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) check("bus answer", 16'h0001, 16'h0000);
        rd = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        ccr       <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd, 1'b0);
    endtask : wr

    task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00, 1'b0);
        check(what, {8'h00, rd}, {8'h00, exp});
    endtask : rchk

    // Loads the count while stopped; byte writes also clear the prescaler.
    task automatic load(input logic [15:0] v);
        wr(IDX_CTRL, 8'h00);
        wr(IDX_CNT_HI, v[15:8]);
        wr(IDX_CNT_LO, v[7:0]);
    endtask : load

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    // Cuts a hang short; the whole sequence needs well under this span.
    initial begin
        repeat (40000) @(posedge mclk);
        bad_count++;
        test_done();
    end

    // Burst of external edges, then a fixed settling gap for the synchroniser.
    task automatic ext_burst(input logic [7:0] n, input logic [7:0] h);
        int w;
        w = 0;
        @(posedge mclk);
        n_edges <= n;
        half    <= h;
        go      <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        while (busy !== 1'b0 && w < 20000) begin
            @(posedge mclk);
            w++;
        end
        if (w >= 20000) check("burst done", 16'h0001, 16'h0000);
        repeat (8) @(posedge mclk);
    endtask : ext_burst

    initial begin
        rst = 1'b1; avs_address = '0; avs_read = 1'b0; avs_write = 1'b0;
        avs_writedata = '0; ccr = 1'b0; sleep_active = 1'b0; port_direction = 2'b01;
        go = 1'b0; n_edges = 8'h00; half = 8'h04; bad_count = 0; n_checks = 0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        // Reset values and the register map.
        rchk("control reset", IDX_CTRL, 8'h00);
        rchk("flags reset", IDX_FLAGS, 8'h00);
        check("count reset", count_value, 16'h0000);
        wr(IDX_CTRL, 8'hfe);
        rchk("control upper bits", IDX_CTRL, 8'h3e);
        rchk("unmapped read", 8'h20, 8'h00);
        // A stopped count holds and is readable and writable.
        load(16'h1234);
        repeat (40) @(posedge mclk);
        rchk("count low held", IDX_CNT_LO, 8'h34);
        rchk("count high held", IDX_CNT_HI, 8'h12);
        check("count held", count_value, 16'h1234);
        // Timer with every prescale; the sync bit is set on the 1:2 and 1:8 ratios and must not matter.
        for (k = 0; k < 4; k++) begin
            load(16'h0000);
            wr(IDX_CTRL, 8'(1 | (k << 4) | ((k & 1) << 2)));
            repeat (8) @(posedge mclk);
            c0 = count_value;
            repeat (8 * INSTR_DIV * (1 << k)) @(posedge mclk);
            check("timer rate", count_value - c0, 16'h0008);
        end
        // Wrap from all ones raises the flag, which stays until cleared.
        load(16'hfffe);
        wr(IDX_ENABLES, 8'h01);
        wr(IDX_CTRL, 8'h01);
        k = 0;
        while (count_value !== 16'h0000 && k < 60) begin
            @(posedge mclk);
            k++;
        end
        check("wrap to zero", count_value, 16'h0000);
        repeat (20) @(posedge mclk);
        rchk("flag latched", IDX_FLAGS, 8'h01);
        check("irq enabled", {15'h0, overflow_irq}, 16'h0001);
        wr(IDX_ENABLES, 8'h00);
        repeat (2) @(posedge mclk);
        check("irq masked", {15'h0, overflow_irq}, 16'h0000);
        wr(IDX_FLAGS, 8'h00);
        rchk("flag cleared", IDX_FLAGS, 8'h00);
        // External counting: sync 1:1, sync 1:2, then async at 200 kHz while asleep.
        load(16'h0000);
        wr(IDX_CTRL, 8'h03);
        ext_burst(8'd10, 8'd4);
        check("sync count", count_value, 16'd10);
        load(16'h0000);
        wr(IDX_CTRL, 8'h13);
        ext_burst(8'd10, 8'd4);
        check("sync prescaled", count_value, 16'd5);
        load(16'h0000);
        wr(IDX_CTRL, 8'h07);
        sleep_active <= 1'b1;
        ext_burst(8'd6, 8'd100);
        check("async in sleep", count_value, 16'd6);
        // Crystal oscillator on forces both shared pins to inputs, also in sleep.
        wr(IDX_CTRL, 8'h08);
        repeat (3) @(posedge mclk);
        check("osc running", {15'h0, crystal_osc_run}, 16'h0001);
        check("pins forced in", {14'h0, shared_pin_oe_n}, 16'h0003);
        repeat (200) @(posedge mclk);
        sleep_active <= 1'b0;
        wr(IDX_CTRL, 8'h00);
        repeat (3) @(posedge mclk);
        check("osc off", {15'h0, crystal_osc_run}, 16'h0000);
        check("pins follow port", {14'h0, shared_pin_oe_n}, 16'h0001);
        // Trigger clear at all ones: count to zero without setting the flag.
        // The trigger is only used with the internal source selected.
        load(16'hffff);
        @(posedge mclk);
        ccr <= 1'b1;
        @(posedge mclk);
        ccr <= 1'b0;
        repeat (3) @(posedge mclk);
        check("trigger clear", count_value, 16'h0000);
        rchk("no flag on clear", IDX_FLAGS, 8'h00);
        // A count write in the same cycle as the trigger wins.
        load(16'h7f00);
        bus(1'b1, IDX_CNT_LO, 8'h55, 1'b1);
        repeat (2) @(posedge mclk);
        check("write beats clear", count_value, 16'h0055);
        test_done();
    end
endmodule : counter16_with_ext_clock_bench
